// ### hdl/ascp_dev.sv
// Converter end: serial configuration receiver, configuration registers, output timing.
// Link logic runs on the host shift clock; the rest runs on the sample clock ref_clk_i.
`timescale 1ns/100ps
module ascp_dev (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  ascp_if.dev link,
  input wire logic oe_i,
  input wire logic [ascp_pkg::SAMPLE_W-1:0] sample_i,
  output logic [ascp_pkg::SAMPLE_W-1:0] data_o,
  output logic data_valid_o,
  output logic timing_stable_o,
  output logic dll_off_o,
  output logic [1:0] test_mode_o,
  output logic power_down_o
);
  import ascp_pkg::*;

  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] word_q;
  logic word_tgl_q;
  logic tgl_s;
  logic tgl_seen_q;
  logic [1:0] arm_q;
  logic word_pulse;
  logic pin_rst_s;
  logic oe_s;
  logic [ADDR_W-1:0] w_addr;
  logic [DATA_W-1:0] w_data;
  logic [SAMPLE_W-1:0] pipe_q [PIPE_RISE];
  logic [CNT_W-1:0] wake_cnt_q;
  logic [CNT_W-1:0] oe_cnt_q;
  logic toggle_q;

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  // Counter is cleared whenever select is high, so each frame starts aligned
  always_ff @(negedge link.shift_clk or posedge link.serial_select_n
              or posedge link.dev_reset) begin
    if (link.dev_reset) begin
      bit_cnt_q <= '0;
    end else if (link.serial_select_n) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(negedge link.shift_clk or posedge link.dev_reset) begin
    if (link.dev_reset) begin
      shift_q <= '0;
    end else if (!link.serial_select_n) begin
      shift_q <= {shift_q[WORD_W-2:0], link.serial_bit_in};
    end
  end

  // Word register stays put for at least sixteen shift clocks after a commit
  always_ff @(negedge link.shift_clk or posedge link.dev_reset) begin
    if (link.dev_reset) begin
      word_q <= '0;
      word_tgl_q <= 1'b0;
    end else if (!link.serial_select_n && bit_cnt_q == 4'hf) begin
      word_q <= {shift_q[WORD_W-2:0], link.serial_bit_in};
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // Crossings into the sample clock domain
  // ---------------------------------------------------------------
  ascp_sync u_tgl_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(word_tgl_q),
    .sync_o(tgl_s)
  );

  ascp_sync u_rst_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(link.dev_reset),
    .sync_o(pin_rst_s)
  );

  ascp_sync u_oe_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(oe_i),
    .sync_o(oe_s)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  // Edge detector stays quiet until the synchroniser shows the true toggle level,
  // so a toggle left over from before a reset does not replay the old word
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_q <= 2'h0;
    end else if (arm_q != 2'h3) begin
      arm_q <= arm_q + 2'h1;
    end
  end

  assign word_pulse = (tgl_s ^ tgl_seen_q) && (arm_q == 2'h3);
  assign w_addr = word_q[WORD_W-1 -: ADDR_W];
  assign w_data = word_q[DATA_W-1:0];

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dll_off_o <= DLL_OFF_RST;
      test_mode_o <= TEST_RST;
      power_down_o <= PDN_RST;
    end else if (pin_rst_s) begin
      dll_off_o <= DLL_OFF_RST;
      test_mode_o <= TEST_RST;
      power_down_o <= PDN_RST;
    end else if (word_pulse) begin
      if (w_addr == ADDR_DLL) begin
        dll_off_o <= w_data[DLL_OFF_BIT];
      end
      if (w_addr == ADDR_TEST) begin
        test_mode_o <= w_data[TEST_LSB +: 2];
      end
      if (w_addr == ADDR_PDN) begin
        power_down_o <= w_data[PDN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Sample pipeline and output stage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PIPE_RISE; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      pipe_q[0] <= sample_i;
      for (int i = 1; i < PIPE_RISE; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  // Falling-edge stage supplies the final half cycle of latency
  always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
    end else if (!oe_s || power_down_o) begin
      data_o <= '0;
    end else begin
      case (test_mode_o)
        TEST_ZERO: data_o <= '0;
        TEST_ONE: data_o <= '1;
        TEST_TOGGLE: data_o <= {SAMPLE_W{toggle_q}};
        default: data_o <= pipe_q[PIPE_RISE-1];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Wake-up and output-enable settling
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt_q <= '0;
      data_valid_o <= 1'b0;
    end else if (power_down_o || pin_rst_s) begin
      wake_cnt_q <= '0;
      data_valid_o <= 1'b0;
    end else if (wake_cnt_q != WAKE_CYC) begin
      wake_cnt_q <= wake_cnt_q + 10'h1;
      data_valid_o <= 1'b0;
    end else begin
      data_valid_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_cnt_q <= '0;
      timing_stable_o <= 1'b0;
    end else if (!oe_s) begin
      oe_cnt_q <= '0;
      timing_stable_o <= 1'b0;
    end else if (oe_cnt_q != OE_STABLE_CYC) begin
      oe_cnt_q <= oe_cnt_q + 10'h1;
      timing_stable_o <= 1'b0;
    end else begin
      timing_stable_o <= 1'b1;
    end
  end
endmodule // ascp_dev

// ### hdl/ascp_host.sv
// Controller end: power-on and reset sequencing, then 16-bit serial register writes.
// Shift clock is divided from ref_clk_i by four and driven onto the link.
`timescale 1ns/100ps
module ascp_host #(
  parameter int POWER_ON_CYC_P = ascp_pkg::POWER_ON_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  ascp_if.host link,
  input wire logic wr_valid_i,
  input wire logic [ascp_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [ascp_pkg::DATA_W-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic link_up_o
);
  import ascp_pkg::*;

  typedef enum {H_PWR, H_RST, H_POST, H_IDLE, H_SHIFT, H_HOLD} ascp_hstate_t;
  ascp_hstate_t state_q;
  logic [WAIT_W-1:0] wait_q;
  logic [1:0] ph_q;
  logic [BIT_CNT_W-1:0] bit_q;
  logic [WORD_W-1:0] shift_q;
  logic sclk_q;
  logic sel_n_q;
  logic rst_pin_q;
  logic word_end;

  assign word_end = (state_q == H_SHIFT) && (ph_q == SCLK_DIV_M1) && (bit_q == 4'hf);
  assign wr_ready_o = (state_q == H_IDLE) || word_end;
  assign link_up_o = (state_q == H_IDLE);
  assign link.shift_clk = sclk_q;
  assign link.serial_select_n = sel_n_q;
  assign link.serial_bit_in = shift_q[WORD_W-1];
  assign link.dev_reset = rst_pin_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= H_PWR;
      wait_q <= '0;
      rst_pin_q <= 1'b0;
    end else begin
      case (state_q)
        H_PWR: begin
          wait_q <= wait_q + 19'h1;
          if (wait_q == WAIT_W'(POWER_ON_CYC_P - 1)) begin
            state_q <= H_RST;
            wait_q <= '0;
            rst_pin_q <= 1'b1;
          end
        end
        H_RST: begin
          wait_q <= wait_q + 19'h1;
          if (wait_q == WAIT_W'(RESET_PULSE_CYC - 1)) begin
            state_q <= H_POST;
            wait_q <= '0;
            rst_pin_q <= 1'b0;
          end
        end
        H_POST: begin
          wait_q <= wait_q + 19'h1;
          if (wait_q == WAIT_W'(WRITE_DELAY_CYC - 1)) begin
            state_q <= H_IDLE;
          end
        end
        H_IDLE: begin
          if (wr_valid_i) begin
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (word_end && !wr_valid_i) begin
            state_q <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (ph_q == SCLK_HALF_M1) begin
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_PWR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shift clock, select and data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      sclk_q <= 1'b1;
      sel_n_q <= 1'b1;
    end else begin
      case (state_q)
        H_IDLE: begin
          ph_q <= '0;
          bit_q <= '0;
          sclk_q <= 1'b1;
          if (wr_valid_i) begin
            shift_q <= {wr_addr_i, wr_data_i};
            sel_n_q <= 1'b0;
          end
        end
        H_SHIFT: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == SCLK_HALF_M1) begin
            sclk_q <= 1'b0;
          end
          if (ph_q == SCLK_DIV_M1) begin
            sclk_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
            if (word_end && wr_valid_i) begin
              shift_q <= {wr_addr_i, wr_data_i};
            end else begin
              shift_q <= {shift_q[WORD_W-2:0], 1'b0};
            end
          end
        end
        H_HOLD: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == SCLK_HALF_M1) begin
            sel_n_q <= 1'b1;
            ph_q <= '0;
          end
        end
        default: begin
          ph_q <= '0;
          sclk_q <= 1'b1;
          sel_n_q <= 1'b1;
        end
      endcase
    end
  end
endmodule // ascp_host

// ### hdl/ascp_sync.sv
// Two-flop level synchroniser.
// Input is asynchronous to clk_i.
`timescale 1ns/100ps
module ascp_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // ascp_sync

// ### shared/ascp_if.sv
// Three-wire configuration link plus the converter reset pin.
// Host drives every wire; the device only listens.
`timescale 1ns/100ps
interface ascp_if;
  logic shift_clk;
  logic serial_select_n;
  logic serial_bit_in;
  logic dev_reset;
  modport dev (input shift_clk, input serial_select_n, input serial_bit_in, input dev_reset);
  modport host (output shift_clk, output serial_select_n, output serial_bit_in,
                output dev_reset);
endinterface

// ### shared/ascp_pkg.sv
// Constants, encodings and timing counts of the serial configuration port.
// Assumes a 40 MHz reference clock on both ends; the link clock is made by the host.
package ascp_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int SAMPLE_W = 12;
  localparam int BIT_CNT_W = 4;
  // ---------------------------------------------------------------
  // Register addresses and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_DLL = 4'hd;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 4'he;
  localparam logic [ADDR_W-1:0] ADDR_PDN = 4'hf;
  localparam int DLL_OFF_BIT = 1;
  localparam int TEST_LSB = 9;
  localparam int PDN_BIT = 11;
  localparam logic DLL_OFF_RST = 1'h0;
  localparam logic [1:0] TEST_RST = 2'h0;
  localparam logic PDN_RST = 1'h0;
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_ZERO = 2'h1;
  localparam logic [1:0] TEST_ONE = 2'h2;
  localparam logic [1:0] TEST_TOGGLE = 2'h3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_NS = 25;
  localparam int POWER_ON_MS = 10;
  localparam int POWER_ON_CYC = (POWER_ON_MS * 1000000 + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int RESET_PULSE_US = 2;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_US * 1000 + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int WRITE_DELAY_US = 2;
  localparam int WRITE_DELAY_CYC = (WRITE_DELAY_US * 1000 + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int WAIT_W = 19;
  localparam int LATENCY_HALF_CYC = 35;
  // Stage 0 catches the sample; the last half cycle is a falling-edge stage
  localparam int PIPE_RISE = LATENCY_HALF_CYC / 2 + 1;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] OE_STABLE_CYC = 10'h3e8;
  localparam logic [CNT_W-1:0] WAKE_CYC = 10'h3e8;
  localparam logic [1:0] SCLK_DIV_M1 = 2'h3;
  localparam logic [1:0] SCLK_HALF_M1 = 2'h1;
endpackage

// ### verification/adc_serial_config_port_tb.sv
// Self-checking bench: host end and converter end joined by one link.
// A second converter end on its own link is driven by the bench for framing faults.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module adc_serial_config_port_tb;
  import ascp_pkg::*;
  localparam int PON = 20;
  logic ref_clk_i, rst_n_i, wr_valid, wr_ready, link_up, oe, data_valid, timing_stable;
  logic dll_off, pd, pd2, lk_clk;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [SAMPLE_W-1:0] sample, data_o;
  logic [1:0] test_mode, test2;
  logic [15:0] mon;
  logic [3:0] flags;
  int nbits, n_fail, tests_run, n;
  ascp_if lk();
  ascp_if lk2();
  ascp_host #(.POWER_ON_CYC_P(PON)) ascp_host_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(lk.host), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .link_up_o(link_up));
  ascp_dev ascp_dev_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(lk.dev), .oe_i(oe),
    .sample_i(sample), .data_o(data_o), .data_valid_o(data_valid),
    .timing_stable_o(timing_stable), .dll_off_o(dll_off), .test_mode_o(test_mode),
    .power_down_o(pd));
  ascp_dev ascp_dev_inst2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(lk2.dev), .oe_i(oe),
    .sample_i(sample), .data_o(), .data_valid_o(), .timing_stable_o(), .dll_off_o(),
    .test_mode_o(test2), .power_down_o(pd2));
  ascp_asserts #(.POWER_ON_CYC_P(PON)) ascp_asserts_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .shift_clk(lk.shift_clk), .serial_select_n(lk.serial_select_n),
    .serial_bit_in(lk.serial_bit_in), .dev_reset(lk.dev_reset));
  assign flags = {wr_ready, timing_stable, data_valid, link_up};
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Link clock for the bench-driven link, unrelated in phase to ref_clk_i
  initial begin
    lk_clk = 1'b0;
    #3.1;
    forever #6 lk_clk = ~lk_clk;
  end
  always @(posedge ref_clk_i) sample <= sample + 12'h001;
  // Word seen on the wire, shifted in at each falling shift edge
  always @(negedge lk.shift_clk) begin
    if (!lk.serial_select_n) begin
      mon <= {mon[14:0], lk.serial_bit_in};
      nbits <= nbits + 1;
    end
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_flag(input int b, input int lim, output int cnt);
    @(negedge ref_clk_i);
    for (cnt = 0; cnt < lim && flags[b] !== 1'b1; cnt++) @(negedge ref_clk_i);
    if (cnt >= lim) begin
      n_fail++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, cnt, lim);
      end_of_test;
    end
  endtask
  task send(input logic [15:0] ws [$]);
    int i;
    for (i = 0; i < ws.size(); i++) begin
      @(posedge ref_clk_i);
      wr_valid <= 1'b1;
      wr_addr <= ws[i][15:12];
      wr_data <= ws[i][11:0];
      wait_flag(3, 200, n);
    end
    @(posedge ref_clk_i);
    wr_valid <= 1'b0;
    wait_flag(0, 300, n);
  endtask
  task bits2(input logic [31:0] w, input int nb);
    int i;
    logic [31:0] s;
    s = w;
    @(posedge lk_clk);
    lk2.serial_select_n <= 1'b0;
    lk2.serial_bit_in <= s[31];
    for (i = 0; i < nb; i++) begin
      @(negedge lk_clk) lk2.shift_clk <= 1'b0;
      @(posedge lk_clk) lk2.shift_clk <= 1'b1;
      s = s << 1;
      lk2.serial_bit_in <= s[31];
    end
    @(posedge lk_clk) lk2.serial_select_n <= 1'b1;
    lk2.serial_bit_in <= ~lk2.serial_bit_in;
    repeat (8) @(posedge ref_clk_i);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_burst;
    nbits = 0;
    send('{16'hd002, 16'he400, 16'hf800});
    `CHK(dll_off, 1'b1)
    `CHK(test_mode, TEST_ONE)
    `CHK(pd, 1'b1)
    `CHK(mon, 16'hf800)
    `CHK(nbits, 48)
  endtask
  task t_wake;
    send('{16'hf000});
    wait_flag(1, 1100, n);
    `CHK(n >= 980 && n <= 1000, 1'b1)
  endtask
  task t_oe;
    `CHK(data_o, 12'h000)
    @(posedge ref_clk_i) oe <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK(data_o, 12'hfff)
    wait_flag(2, 1100, n);
    `CHK(n >= 1000 && n <= 1004, 1'b1)
  endtask
  task t_modes;
    int m;
    logic [11:0] p;
    for (m = 1; m < 5; m++) begin
      send('{{4'he, 1'b0, 2'(m % 4), 9'h000}});
      repeat (20) @(posedge ref_clk_i);
      case (m)
        1: `CHK(data_o, 12'h000)
        2: `CHK(data_o, 12'hfff)
        3: begin
          p = data_o;
          @(posedge ref_clk_i);
          `CHK(data_o, ~p)
        end
        default: `CHK(data_o, sample - 12'd18)
      endcase
    end
  endtask
  task t_partial;
    bits2({16'he400, 16'hffff}, 20);
    `CHK(test2, TEST_ONE)
    bits2(32'hff000000, 8);
    `CHK(test2, TEST_ONE)
    bits2({16'he600, 16'h0000}, 16);
    `CHK(test2, TEST_TOGGLE)
    `CHK(pd2, 1'b0)
  endtask
  task t_rereset;
    @(posedge ref_clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wait_flag(0, 400, n);
    `CHK({dll_off, test_mode, pd}, 4'h0)
    `CHK(test2, TEST_NORMAL)
  endtask
  initial begin
    rst_n_i = 1'b0;
    {wr_valid, wr_addr, wr_data, oe, sample, mon} = '0;
    {n_fail, tests_run, nbits} = '0;
    lk2.shift_clk = 1'b1;
    lk2.serial_select_n = 1'b1;
    lk2.serial_bit_in = 1'b0;
    lk2.dev_reset = 1'b0;
    @(posedge ref_clk_i) lk2.dev_reset <= 1'b1;
    @(posedge ref_clk_i) rst_n_i <= 1'b1;
    wait_flag(0, 400, n);
    @(posedge ref_clk_i) lk2.dev_reset <= 1'b0;
    t_burst;
    t_wake;
    t_oe;
    t_modes;
    t_partial;
    t_rereset;
    end_of_test;
  end
endmodule // adc_serial_config_port_tb

// ### verification/ascp_asserts.sv
// Concurrent checks on the wires of the configuration link.
// Instantiated beside the interface; every wire is driven by the host end.
`timescale 1ns/100ps
module ascp_asserts #(
  parameter int POWER_ON_CYC_P = ascp_pkg::POWER_ON_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic shift_clk,
  input wire logic serial_select_n,
  input wire logic serial_bit_in,
  input wire logic dev_reset
);
  import ascp_pkg::*;
  logic sclk_q;
  logic [7:0] fall_cnt_q;
  int hi_cnt_q;
  int lo_cnt_q;
  int up_cnt_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) sclk_q <= 1'b1;
    else sclk_q <= shift_clk;
  end
  // Falling shift edges inside the current frame
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fall_cnt_q <= 8'h00;
    else if (serial_select_n) fall_cnt_q <= 8'h00;
    else if (sclk_q && !shift_clk) fall_cnt_q <= fall_cnt_q + 8'h01;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hi_cnt_q <= 0;
    else if (dev_reset) hi_cnt_q <= hi_cnt_q + 1;
    else hi_cnt_q <= 0;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lo_cnt_q <= 0;
    else if (dev_reset) lo_cnt_q <= 0;
    else if (lo_cnt_q < 1000) lo_cnt_q <= lo_cnt_q + 1;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_cnt_q <= 0;
    else if (up_cnt_q <= POWER_ON_CYC_P) up_cnt_q <= up_cnt_q + 1;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_sclk_idle_high: assert property (serial_select_n |-> shift_clk)
    else $error("shift clock low outside a frame");
  a_low_half: assert property ($fell(shift_clk) |=> !shift_clk ##1 shift_clk)
    else $error("shift clock low phase not two cycles");
  a_data_at_fall: assert property ($fell(shift_clk) |-> $stable(serial_bit_in))
    else $error("serial data moved at falling shift edge");
  a_frame_hold: assert property ($fell(serial_select_n) |=> !serial_select_n [*8])
    else $error("frame select released too early");
  a_whole_words: assert property ($rose(serial_select_n) |->
      (fall_cnt_q != 8'h00 && fall_cnt_q[3:0] == 4'h0))
    else $error("frame not a whole number of words");
  a_reset_width: assert property ($fell(dev_reset) |-> hi_cnt_q >= RESET_PULSE_CYC)
    else $error("converter reset pulse too short");
  a_write_delay: assert property ($fell(serial_select_n) |-> lo_cnt_q >= WRITE_DELAY_CYC)
    else $error("frame started too soon after reset");
  a_power_on: assert property ($rose(dev_reset) |-> up_cnt_q >= POWER_ON_CYC_P - 1)
    else $error("reset pulse before power-on delay");
  c_burst: cover property ($rose(serial_select_n) && fall_cnt_q == 8'h30);
  c_reset: cover property ($fell(dev_reset));
  c_frame: cover property ($fell(serial_select_n));
endmodule // ascp_asserts
